/* File: core/cmd_major_map.vh */
// constants for the compact major opcode decoder
// assumes inclusion by bare name from the decoder files
`ifndef CMD_MAJOR_MAP_VH
`define CMD_MAJOR_MAP_VH

// major field position in the fetched word
`define CMD_MAJOR_HI 31
`define CMD_MAJOR_LO 26
`define CMD_MAJOR_W 6

// register and sub-opcode fields used to split shared groups
`define CMD_RT_HI 25
`define CMD_RT_LO 21
`define CMD_RS_HI 20
`define CMD_RS_LO 16
`define CMD_SUB_HI 5
`define CMD_SUB_LO 0

// encoding classes
`define CMD_CLS_W 4
`define CMD_C_DIRECT 4'h0
`define CMD_C_POOL 4'h1
`define CMD_C_RSVD 4'h2
`define CMD_C_SHARED 4'h3
`define CMD_C_W64 4'h4
`define CMD_C_W64_COP 4'h5
`define CMD_C_COP1 4'h6
`define CMD_C_FP64 4'h7
`define CMD_C_CORR 4'h8
`define CMD_C_PARTNER 4'h9
`define CMD_C_DEBUG 4'ha
`define CMD_C_EXT 4'hb
`define CMD_C_HIGHER 4'hc

// pool identifiers
`define CMD_POOL_W 4
`define CMD_POOL_N 10
`define CMD_P_W32A 4'h0
`define CMD_P_W32B 4'h1
`define CMD_P_W32I 4'h2
`define CMD_P_W32C 4'h3
`define CMD_P_N16A 4'h4
`define CMD_P_N16B 4'h5
`define CMD_P_N16C 4'h6
`define CMD_P_N16D 4'h7
`define CMD_P_N16E 4'h8
`define CMD_P_W32F 4'h9
`define CMD_P_NONE 4'hf

// rows of the major table
`define CMD_ROW_WIDE0 3'h0
`define CMD_ROW_N16LO 3'h1
`define CMD_ROW_N16HI 3'h3
`define CMD_ROW_IMM 3'h4

// coprocessor numbers
`define CMD_CP0 2'h0
`define CMD_CP1 2'h1

`endif

/* File: core/cmd_out_reg.v */
// output flop stage for decoder results
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/100ps

module cmd_out_reg #(
    parameter W = 1,
    parameter [W-1:0] RST = {W{1'b0}}
)(
    // clock and reset
    input wire i_clk,
    input wire i_resetn,
    // data
    input wire [W-1:0] i_d,
    output reg [W-1:0] o_q
);

always @(posedge i_clk or negedge i_resetn)
begin
    if (!i_resetn)
    begin
        o_q <= RST;
    end
    else
    begin
        o_q <= i_d;
    end
end

endmodule // cmd_out_reg

/* File: core/cmd_major_decoder.v */
// major opcode decoder for a mixed 16/32-bit compressed instruction set
// assumes the fetch stage puts the first halfword in bits 31:16
// and the pipeline supplies mode bits on the same clock
//
// Operation
// - major is the top six bits: bit 15 down or bit 31 down
// - major field is always six bits; minor fields vary per pool
// - major value is column bits above row bits
// - pool majors identify nothing alone; word goes to the pool decoder
// - non-pool majors name one instruction or one shared group
// - shared majors are split by other instruction fields
// - reserved encodings request reserved-instruction
// - field-class encodings go to the further table first
// - higher-level or newer-revision encodings request reserved-instruction
// - 64-bit-only encodings legal only with 64-bit ops enabled
// - from revision 2, 64-bit-float encodings need 64-bit float enabled
// - corrected encodings legal in any configuration from revision 2
// - empty partner encodings request reserved or coprocessor-unusable
// - extension encodings reserved when the extension is absent
// - row 000 holds four wide pools then compact branch groups
// - row 001 holds narrow pools, global-pointer load, then reserved
// - row 100 holds the wide immediate operations in column order
`timescale 1ns/100ps
`include "cmd_major_map.vh"

module cmd_major_decoder #(
    parameter DEBUG_IMPL = 0,
    parameter EXT_IMPL = 0,
    parameter REV2 = 1
)(
    // clock and reset
    input wire i_clk,
    input wire i_resetn,
    // fetch side
    input wire i_valid,
    input wire [31:0] i_instr,
    // mode bits
    input wire i_ops64_en,
    input wire i_fp64_en,
    input wire i_fp_register_file_mode,
    input wire i_cop1_usable,
    input wire i_cop2_usable,
    // decode result
    output wire o_valid,
    output wire [31:0] o_instr,
    output wire [5:0] o_major,
    output wire [3:0] o_class,
    output wire o_narrow,
    output wire [`CMD_POOL_N-1:0] o_pool_sel,
    output wire o_shared,
    output wire o_rs_zero,
    output wire o_rt_zero,
    output wire o_rs_lt_rt,
    output wire [5:0] o_sub_op,
    output wire o_imm_op_valid,
    output wire [2:0] o_imm_op,
    // exception requests
    output wire o_ri_req,
    output wire o_cpu_req,
    output wire [1:0] o_cpu_unit
);

// ----------------------------------------
// field extraction
// ----------------------------------------
wire [5:0] major;
wire [2:0] col;
wire [2:0] row;
wire [4:0] rs_f;
wire [4:0] rt_f;

assign major = i_instr[`CMD_MAJOR_HI:`CMD_MAJOR_LO];
assign col = major[5:3];
assign row = major[2:0];
assign rs_f = i_instr[`CMD_RS_HI:`CMD_RS_LO];
assign rt_f = i_instr[`CMD_RT_HI:`CMD_RT_LO];

// ----------------------------------------
// major table
// ----------------------------------------
reg [3:0] cls;

always @*
begin
    case (major)
        6'h00: cls = `CMD_C_POOL;
        6'h01: cls = `CMD_C_POOL;
        6'h02: cls = `CMD_C_DIRECT;
        6'h03: cls = `CMD_C_DIRECT;
        6'h04: cls = `CMD_C_DIRECT;
        6'h05: cls = `CMD_C_DIRECT;
        6'h06: cls = `CMD_C_DIRECT;
        6'h07: cls = `CMD_C_DIRECT;
        6'h08: cls = `CMD_C_POOL;
        6'h09: cls = `CMD_C_POOL;
        6'h0a: cls = `CMD_C_DIRECT;
        6'h0b: cls = `CMD_C_DIRECT;
        6'h0c: cls = `CMD_C_DIRECT;
        6'h0d: cls = `CMD_C_DIRECT;
        6'h0e: cls = `CMD_C_DIRECT;
        6'h0f: cls = `CMD_C_DIRECT;
        6'h10: cls = `CMD_C_POOL;
        6'h11: cls = `CMD_C_POOL;
        6'h12: cls = `CMD_C_DIRECT;
        6'h13: cls = `CMD_C_POOL;
        6'h14: cls = `CMD_C_DIRECT;
        6'h15: cls = `CMD_C_POOL;
        6'h16: cls = `CMD_C_RSVD;
        6'h17: cls = `CMD_C_W64;
        6'h18: cls = `CMD_C_POOL;
        6'h19: cls = `CMD_C_DIRECT;
        6'h1a: cls = `CMD_C_DIRECT;
        6'h1b: cls = `CMD_C_POOL;
        6'h1c: cls = `CMD_C_DIRECT;
        6'h1d: cls = `CMD_C_SHARED;
        6'h1e: cls = `CMD_C_DIRECT;
        6'h1f: cls = `CMD_C_SHARED;
        6'h20: cls = `CMD_C_SHARED;
        6'h21: cls = `CMD_C_RSVD;
        6'h22: cls = `CMD_C_DIRECT;
        6'h23: cls = `CMD_C_DIRECT;
        6'h24: cls = `CMD_C_DIRECT;
        6'h25: cls = `CMD_C_DIRECT;
        6'h26: cls = `CMD_C_COP1;
        6'h27: cls = `CMD_C_COP1;
        6'h28: cls = `CMD_C_SHARED;
        6'h29: cls = `CMD_C_RSVD;
        6'h2a: cls = `CMD_C_DIRECT;
        6'h2b: cls = `CMD_C_DIRECT;
        6'h2c: cls = `CMD_C_DIRECT;
        6'h2d: cls = `CMD_C_DIRECT;
        6'h2e: cls = `CMD_C_COP1;
        6'h2f: cls = `CMD_C_COP1;
        6'h30: cls = `CMD_C_SHARED;
        6'h31: cls = `CMD_C_RSVD;
        6'h32: cls = `CMD_C_DIRECT;
        6'h33: cls = `CMD_C_DIRECT;
        6'h34: cls = `CMD_C_DIRECT;
        6'h35: cls = `CMD_C_SHARED;
        6'h36: cls = `CMD_C_W64;
        6'h37: cls = `CMD_C_W64;
        6'h38: cls = `CMD_C_SHARED;
        6'h39: cls = `CMD_C_RSVD;
        6'h3a: cls = `CMD_C_DIRECT;
        6'h3b: cls = `CMD_C_DIRECT;
        6'h3c: cls = `CMD_C_DIRECT;
        6'h3d: cls = `CMD_C_SHARED;
        6'h3e: cls = `CMD_C_DIRECT;
        6'h3f: cls = `CMD_C_DIRECT;
        default: cls = `CMD_C_RSVD;
    endcase
end

// ----------------------------------------
// pool routing
// ----------------------------------------
reg [3:0] pool_id;
reg [`CMD_POOL_N-1:0] pool_sel;

always @*
begin
    case (major)
        6'h00: pool_id = `CMD_P_W32A;
        6'h08: pool_id = `CMD_P_W32B;
        6'h10: pool_id = `CMD_P_W32I;
        6'h18: pool_id = `CMD_P_W32C;
        6'h01: pool_id = `CMD_P_N16A;
        6'h09: pool_id = `CMD_P_N16B;
        6'h11: pool_id = `CMD_P_N16C;
        6'h13: pool_id = `CMD_P_N16D;
        6'h1b: pool_id = `CMD_P_N16E;
        6'h15: pool_id = `CMD_P_W32F;
        default: pool_id = `CMD_P_NONE;
    endcase
end

// one-hot select, none when the major names an instruction itself
always @*
begin
    pool_sel = {`CMD_POOL_N{1'b0}};
    if (cls == `CMD_C_POOL)
    begin
        pool_sel[pool_id] = 1'b1;
    end
end

// ----------------------------------------
// length and immediate group
// ----------------------------------------
wire narrow;
wire imm_op_valid;

// rows 001..011 are halfword instructions
assign narrow = (row >= `CMD_ROW_N16LO) && (row <= `CMD_ROW_N16HI);
assign imm_op_valid = (row == `CMD_ROW_IMM);

// ----------------------------------------
// shared group hints
// ----------------------------------------
wire shared;
wire rs_zero;
wire rt_zero;
wire rs_lt_rt;

// one major, several instructions: fields below tell them apart
assign shared = (cls == `CMD_C_SHARED);
assign rs_zero = (rs_f == 5'h00);
assign rt_zero = (rt_f == 5'h00);
assign rs_lt_rt = (rs_f < rt_f);

// ----------------------------------------
// exception requests
// ----------------------------------------
reg ri_raw;
reg cpu_raw;
reg [1:0] cpu_unit;
wire fp64_legal;
wire corr_legal;

// before revision 2 the float-64 forms followed the 64-bit ops enable
assign fp64_legal = (REV2 != 0) ? i_fp64_en : i_ops64_en;
// for corrected forms the 64-bit ops enable does not matter from revision 2 onward
assign corr_legal = (REV2 != 0) ? 1'b1 : i_ops64_en;

always @*
begin
    ri_raw = 1'b0;
    cpu_raw = 1'b0;
    cpu_unit = `CMD_CP0;
    case (cls)
        `CMD_C_RSVD:
        begin
            ri_raw = 1'b1;
        end
        `CMD_C_HIGHER:
        begin
            ri_raw = 1'b1;
        end
        `CMD_C_W64:
        begin
            ri_raw = !i_ops64_en;
        end
        `CMD_C_W64_COP:
        begin
            cpu_unit = `CMD_CP1;
            ri_raw = !i_ops64_en && i_cop1_usable;
            cpu_raw = !i_ops64_en && !i_cop1_usable;
        end
        `CMD_C_COP1:
        begin
            cpu_unit = `CMD_CP1;
            cpu_raw = !i_cop1_usable;
        end
        `CMD_C_FP64:
        begin
            cpu_unit = `CMD_CP1;
            ri_raw = !fp64_legal && i_cop1_usable;
            cpu_raw = !fp64_legal && !i_cop1_usable;
        end
        `CMD_C_CORR:
        begin
            cpu_unit = `CMD_CP1;
            ri_raw = !corr_legal && i_cop1_usable;
            cpu_raw = !corr_legal && !i_cop1_usable;
        end
        `CMD_C_PARTNER:
        begin
            // partner slots on the coprocessor two side
            cpu_unit = 2'h2;
            ri_raw = i_cop2_usable;
            cpu_raw = !i_cop2_usable;
        end
        `CMD_C_DEBUG:
        begin
            ri_raw = (DEBUG_IMPL == 0);
        end
        `CMD_C_EXT:
        begin
            ri_raw = (EXT_IMPL == 0);
        end
        default:
        begin
            ri_raw = 1'b0;
            cpu_raw = 1'b0;
        end
    endcase
end

// exactly one request at most
wire ri_req;
wire cpu_req;

assign cpu_req = i_valid && cpu_raw;
assign ri_req = i_valid && ri_raw && !cpu_raw;

// ----------------------------------------
// output stage
// ----------------------------------------
wire [8:0] flags_d;
wire [8:0] flags_q;

assign flags_d = {i_valid, narrow && i_valid, shared && i_valid, rs_zero, rt_zero,
    rs_lt_rt, imm_op_valid && i_valid, ri_req, cpu_req};

cmd_out_reg #(
    .W(9),
    .RST(9'h000)
) u_flags (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_d(flags_d),
    .o_q(flags_q)
);

assign o_valid = flags_q[8];
assign o_narrow = flags_q[7];
assign o_shared = flags_q[6];
assign o_rs_zero = flags_q[5];
assign o_rt_zero = flags_q[4];
assign o_rs_lt_rt = flags_q[3];
assign o_imm_op_valid = flags_q[2];
assign o_ri_req = flags_q[1];
assign o_cpu_req = flags_q[0];

cmd_out_reg #(
    .W(32),
    .RST(32'h00000000)
) u_instr (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_d(i_instr),
    .o_q(o_instr)
);

wire [12:0] code_d;

assign code_d = {major, cls, col};

cmd_out_reg #(
    .W(13),
    .RST({6'h00, `CMD_C_RSVD, 3'h0})
) u_code (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_d(code_d),
    .o_q({o_major, o_class, o_imm_op})
);

wire [`CMD_POOL_N-1:0] pool_d;

assign pool_d = i_valid ? pool_sel : {`CMD_POOL_N{1'b0}};

cmd_out_reg #(
    .W(`CMD_POOL_N),
    .RST({`CMD_POOL_N{1'b0}})
) u_pool (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_d(pool_d),
    .o_q(o_pool_sel)
);

wire [7:0] misc_d;

// sub-opcode for shared sub tables, coprocessor number for the request
assign misc_d = {i_instr[`CMD_SUB_HI:`CMD_SUB_LO], cpu_unit};

cmd_out_reg #(
    .W(8),
    .RST(8'h00)
) u_misc (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_d(misc_d),
    .o_q({o_sub_op, o_cpu_unit})
);

// register-file mode has no effect on major decode
wire unused_rf_mode;

assign unused_rf_mode = i_fp_register_file_mode;

endmodule // cmd_major_decoder

/* File: dv/cmd_fetch_model.sv */
// fetch stage model feeding the major opcode decoder
// assumes bench requests change on the falling edge of i_clk
`timescale 1ns/100ps

module cmd_fetch_model (
    // clock
    input wire i_clk,
    // requests from the bench
    input wire i_req_valid,
    input wire [31:0] i_req_word,
    // toward the decoder
    output wire o_valid,
    output wire [31:0] o_word
);
    reg [31:0] last_reg = 32'h0;

    // idle slots carry a changing pattern: the complement of the last word, then the word again
    assign o_valid = i_req_valid;
    assign o_word = i_req_valid ? i_req_word : ~last_reg;

    always @(posedge i_clk)
        last_reg <= o_word;
endmodule // cmd_fetch_model

/* File: dv/cmd_major_chk.sv */
// port assertions for the major opcode decoder
// assumes binding into cmd_major_decoder with its parameters
`timescale 1ns/100ps
`include "cmd_major_map.vh"

module cmd_major_chk #(
    parameter DEBUG_IMPL = 0,
    parameter EXT_IMPL = 0,
    parameter REV2 = 1
)(
    // clock and reset
    input wire i_clk,
    input wire i_resetn,
    // fetch side
    input wire i_valid,
    input wire [31:0] i_instr,
    input wire i_ops64_en,
    input wire i_cop1_usable,
    // decode result
    input wire o_valid,
    input wire [31:0] o_instr,
    input wire [5:0] o_major,
    input wire [3:0] o_class,
    input wire o_narrow,
    input wire [`CMD_POOL_N-1:0] o_pool_sel,
    input wire o_imm_op_valid,
    input wire [2:0] o_imm_op,
    input wire o_ri_req,
    input wire o_cpu_req,
    input wire [1:0] o_cpu_unit
);
    wire [5:0] in_major = i_instr[31:26];

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    AST_MAJOR_TOP: assert property (i_valid |=> o_valid && o_major == $past(in_major))
        else $error("major not taken from top bits");
    AST_MAJOR_SPLIT: assert property (o_valid |-> o_major == o_instr[31:26])
        else $error("major not column over row");
    AST_NARROW: assert property (o_valid |-> o_narrow == (o_major[2:0] inside {[1:3]}))
        else $error("length flag wrong");
    AST_POOL: assert property (o_valid && o_class == `CMD_C_POOL |-> $onehot(o_pool_sel))
        else $error("pool select not one-hot");
    AST_NONPOOL: assert property (o_class != `CMD_C_POOL |-> o_pool_sel == '0)
        else $error("pool select on non-pool");
    AST_RSVD: assert property (o_valid && o_class == `CMD_C_RSVD |-> o_ri_req)
        else $error("reserved without request");
    AST_ROW0: assert property (o_valid && o_major[5:3] < 3'h4 && o_major[2:0] == 3'h0
        |-> o_class == `CMD_C_POOL)
        else $error("row zero wide pool missed");
    AST_ROW1: assert property (o_valid && o_major[5] && o_major[2:0] == 3'h1
        |-> o_class == `CMD_C_RSVD)
        else $error("row one reserved missed");
    AST_IMM: assert property (o_imm_op_valid |-> o_major[2:0] == 3'h4 && o_imm_op == o_major[5:3])
        else $error("immediate op wrong");
    AST_W64: assert property (i_valid && !i_ops64_en
        && (in_major == 6'h17 || in_major[5:1] == 5'h1b)
        |=> o_ri_req && !o_cpu_req)
        else $error("64-bit only not refused");
    AST_COP1: assert property (i_valid && !i_cop1_usable && in_major[5:4] == 2'h2
        && in_major[2:1] == 2'h3 |=> o_cpu_req && !o_ri_req && o_cpu_unit == 2'h1)
        else $error("coprocessor unusable missed");
    AST_ONE_REQ: assert property (!(o_ri_req && o_cpu_req))
        else $error("two exception requests");

    cover property (o_valid && o_class == `CMD_C_POOL);
    cover property (o_cpu_req);
    cover property (o_ri_req && o_narrow);
endmodule // cmd_major_chk

bind cmd_major_decoder cmd_major_chk #(.DEBUG_IMPL(DEBUG_IMPL), .EXT_IMPL(EXT_IMPL), .REV2(REV2))
    u_chk (.i_clk, .i_resetn, .i_valid, .i_instr, .i_ops64_en, .i_cop1_usable, .o_valid, .o_instr,
    .o_major, .o_class, .o_narrow, .o_pool_sel, .o_imm_op_valid, .o_imm_op, .o_ri_req, .o_cpu_req,
    .o_cpu_unit);

/* File: dv/tb_cmd_major_decoder.sv */
// self-checking bench for the major opcode decoder
// assumes the fetch model and checker are compiled before it
`timescale 1ns/100ps
`include "cmd_major_map.vh"
`define CMD_CHECK(name, exp, got) \
    begin \
        samples_checked = samples_checked + 1; \
        if ((got) !== (exp)) \
        begin \
            failures = failures + 1; \
            $display("[FAIL] %s expected %h seen %h", name, exp, got); \
        end \
    end

module tb_cmd_major_decoder;
    reg i_clk = 1'b0;
    reg i_resetn = 1'b0;
    reg req_valid = 1'b0;
    reg [31:0] req_word = 32'h0;
    reg [31:0] r;
    reg [4:0] modes = 5'h0;
    integer seed = 50;
    integer failures = 0;
    integer samples_checked = 0;
    integer n;
    logic [70:0] notes[$];
    logic [70:0] note;
    wire f_valid, o_valid, o_narrow, o_ri_req, o_cpu_req;
    wire o_shared, o_rs_zero, o_rt_zero, o_rs_lt_rt, o_imm_op_valid;
    wire [31:0] o_instr;
    wire [5:0] o_sub_op;
    wire [2:0] o_imm_op;
    wire [1:0] o_cpu_unit;
    wire [31:0] f_word;
    wire [5:0] o_major;
    wire [3:0] o_class;
    wire [`CMD_POOL_N-1:0] o_pool_sel;
    localparam [59:0] POOLS = {6'h15, 6'h1b, 6'h13, 6'h11, 6'h09, 6'h01, 6'h18, 6'h10, 6'h08, 6'h00};
    wire [22:0] o_decode = {o_major, o_class, o_narrow, o_ri_req, o_cpu_req, o_pool_sel};
    wire [47:0] o_fields = {o_instr, o_shared, o_rs_zero, o_rt_zero, o_rs_lt_rt, o_sub_op,
        o_imm_op_valid, o_imm_op, o_cpu_unit};

    always #12.5 i_clk = ~i_clk;

    cmd_fetch_model fetch_u (.i_clk(i_clk), .i_req_valid(req_valid), .i_req_word(req_word),
        .o_valid(f_valid), .o_word(f_word));

    cmd_major_decoder dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_valid(f_valid),
        .i_instr(f_word), .i_ops64_en(modes[0]), .i_fp64_en(modes[1]),
        .i_fp_register_file_mode(modes[2]), .i_cop1_usable(modes[3]), .i_cop2_usable(modes[4]),
        .o_valid(o_valid), .o_instr(o_instr), .o_major(o_major), .o_class(o_class),
        .o_narrow(o_narrow), .o_pool_sel(o_pool_sel), .o_shared(o_shared),
        .o_rs_zero(o_rs_zero), .o_rt_zero(o_rt_zero), .o_rs_lt_rt(o_rs_lt_rt),
        .o_sub_op(o_sub_op), .o_imm_op_valid(o_imm_op_valid), .o_imm_op(o_imm_op),
        .o_ri_req(o_ri_req), .o_cpu_req(o_cpu_req), .o_cpu_unit(o_cpu_unit));

    function automatic [70:0] expect_of(input [31:0] w, input ops64, input cop1);
        reg [5:0] m;
        reg [3:0] cls;
        reg [9:0] pool;
        integer k;
        begin
            m = w[31:26];
            pool = 10'h0;
            for (k = 0; k < 10; k = k + 1)
                pool[k] = (POOLS[6*k +: 6] == m);
            case (m)
                6'h20, 6'h28, 6'h30, 6'h38, 6'h1d, 6'h1f, 6'h35, 6'h3d: cls = `CMD_C_SHARED;
                6'h16, 6'h21, 6'h29, 6'h31, 6'h39: cls = `CMD_C_RSVD;
                6'h17, 6'h36, 6'h37: cls = `CMD_C_W64;
                6'h26, 6'h27, 6'h2e, 6'h2f: cls = `CMD_C_COP1;
                default: cls = (pool != 10'h0) ? `CMD_C_POOL : `CMD_C_DIRECT;
            endcase
            expect_of = {w, (cls == `CMD_C_SHARED), (w[20:16] == 5'h00), (w[25:21] == 5'h00),
                (w[20:16] < w[25:21]), w[5:0], (m[2:0] == 3'h4), m[5:3],
                ((cls == `CMD_C_COP1) ? 2'h1 : 2'h0),
                m, cls, (m[2:0] != 3'h0 && m[2:0] <= 3'h3),
                (cls == `CMD_C_RSVD || (cls == `CMD_C_W64 && !ops64)),
                (cls == `CMD_C_COP1 && !cop1), pool};
        end
    endfunction

    task send(input v, input [31:0] w);
        begin
            @(negedge i_clk);
            req_valid = v;
            req_word = w;
            modes = $random(seed);
            if (v)
                notes.push_back(expect_of(w, modes[0], modes[3]));
        end
    endtask

    always @(negedge i_clk)
        if (o_valid === 1'b1)
        begin
            note = notes.pop_front();
            `CMD_CHECK("decode", note[22:0], o_decode)
            `CMD_CHECK("fields", note[70:23], o_fields)
        end

    task results;
        begin
            $display("checked %0d failures %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    initial
    begin
        repeat (2000) @(posedge i_clk);
        failures = failures + 1;
        results;
    end

    initial
    begin
        repeat (16) @(posedge i_clk);
        @(negedge i_clk);
        i_resetn = 1'b1;
        for (n = 0; n < 256; n = n + 1)
            send(1'b1, {n[5:0], 26'h0} | ($random(seed) & 32'h03ffffff));
        $display("sweep of all majors done");
        for (n = 0; n < 400; n = n + 1)
        begin
            r = $random(seed);
            send(r[0], $random(seed));
        end
        $display("random gapped stream done");
        send(1'b0, 32'h0);
        send(1'b0, 32'h0);
        @(negedge i_clk);
        i_resetn = 1'b0;
        #1;
        `CMD_CHECK("reset class", `CMD_C_RSVD, o_class)
        `CMD_CHECK("reset valid", 1'b0, o_valid)
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        i_resetn = 1'b1;
        send(1'b1, 32'h84000000);
        send(1'b1, 32'hdc000000);
        send(1'b0, 32'h0);
        repeat (2) @(posedge i_clk);
        $display("mid-run reset done");
        `CMD_CHECK("notes left", 0, notes.size())
        results;
    end
endmodule // tb_cmd_major_decoder
